// ===== verilog/phylc_pkg.sv
package phylc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0]  PHYLC_IDX_CTL_TWO   = 6'h0a;
    localparam logic [5:0]  PHYLC_IDX_CTL_THREE = 6'h0b;
    localparam logic [5:0]  PHYLC_IDX_STATUS    = 6'h0c;
    localparam logic [7:0]  PHYLC_ADR_CTL_TWO   = {PHYLC_IDX_CTL_TWO, 2'b00};
    localparam logic [7:0]  PHYLC_ADR_CTL_THREE = {PHYLC_IDX_CTL_THREE, 2'b00};
    localparam logic [7:0]  PHYLC_ADR_STATUS    = {PHYLC_IDX_STATUS, 2'b00};

    // Reset values
    localparam logic [15:0] PHYLC_CTL_TWO_RST   = 16'h0100;
    localparam logic [15:0] PHYLC_CTL_THREE_RST = 16'h1000;

    // link_control_two fields
    localparam int PHYLC_B_PD_FAST   = 6;
    localparam int PHYLC_B_EXT_FD    = 5;
    localparam int PHYLC_B_ENH_LED   = 4;
    localparam int PHYLC_B_ISOLATE   = 3;
    localparam int PHYLC_B_IDLE_ERR  = 2;
    localparam int PHYLC_B_ODD_DIS   = 1;
    localparam int PHYLC_B_RMII_RCLK = 0;

    // link_control_three fields
    localparam int PHYLC_B_EQ_BYP    = 12;
    localparam int PHYLC_B_DESC_DROP = 10;
    localparam int PHYLC_FLD_MSB     = 3;

    // Outputs toward the PHY datapath and the MAC side
    typedef struct packed {
        logic pd_fast;
        logic full_duplex;
        logic led_link;
        logic mii_isolate;
        logic rx_er_idle;
        logic tx_en;
        logic tx_er;
        logic rmii_rclk_sel;
        logic eq_err;
        logic link_drop;
    } phylc_ctl_s;

    typedef struct packed {
        logic [15:0] ctl_two;
        logic [15:0] ctl_three;
        logic        ack;
        logic [31:0] dat;
        logic        tx_en_d;
        logic        nib_odd;
        phylc_ctl_s  ctl;
    } phylc_state_s;

endpackage

// ===== verilog/phylc_top.sv
// Functional notes
// R1: Fast link-up bit shortens parallel-detect link-up; zero keeps normal detection.
// R2: Fast link-up bit sets itself when fast or robust crossover is enabled.
// R3: Extended duplex forces full duplex when partner is forced 100Base-TX.
// R4: Without extended duplex, duplex follows the standard resolution result.
// R5: Enhanced LED lights only for an established 100Base-TX full-duplex link.
// R6: Enhanced LED suppresses transmit and receive activity blinking.
// R7: Normal LED lights for any established link.
// R8: Isolate bit blanks MII outputs on 100 half duplex or any 10 link.
// R9: Idle receive symbol errors are reported only while the idle bit is set.
// R10: Odd-nibble transmit error detection runs while its disable bit is zero.
// R11: Odd nibble stretches transmit enable one cycle, flagged as transmit error.
// R12: In RMII, receive clock bit picks RX_CLK or the reference clock.
// R13: Equalizer bypass bit, set at reset, masks equalizer error indications.
// R14: Descrambler drop bit drops the link on descrambler lock loss.
// R15: Descrambler drop combines with the low four fast link down modes.
// R16: Software writes reserved bits with defaults and ignores them on read.
`timescale 1ns/1ns
module phylc_top
    import phylc_pkg::*;
(
    input  wire logic        clk_i,              // 50 MHz system clock
    input  wire logic        sys_rst_i,          // Synchronous reset, active high
    input  wire logic        ce_i,               // Clock enable, freezes all state
    input  wire logic        wb_cyc_i,           // Wishbone cycle
    input  wire logic        wb_stb_i,           // Wishbone strobe
    input  wire logic        wb_we_i,            // Wishbone write enable
    input  wire logic [7:0]  wb_adr_i,           // Wishbone byte address
    input  wire logic [3:0]  wb_sel_i,           // Wishbone byte selects
    input  wire logic [31:0] wb_dat_i,           // Wishbone write data
    output logic      [31:0] wb_dat_o,           // Wishbone read data
    output logic             wb_ack_o,           // Wishbone acknowledge
    input  wire logic        mdix_fast_i,        // Fast crossover enabled
    input  wire logic        mdix_robust_i,      // Robust crossover enabled
    input  wire logic        link_up_i,          // Link established
    input  wire logic        link_100_i,         // Link runs 100Base-TX
    input  wire logic        ieee_full_i,        // Standard duplex resolution says full
    input  wire logic        local_an_i,         // Local side auto-negotiating
    input  wire logic        local_f100_i,       // Local side forced 100Base-TX
    input  wire logic        partner_f100_i,     // Partner detected as forced 100Base-TX
    input  wire logic        activity_i,         // Tx/rx activity blink request
    input  wire logic        idle_sym_err_i,     // Symbol error seen in idle
    input  wire logic        tx_tick_i,          // One pulse per transmit clock cycle
    input  wire logic        tx_en_i,            // Transmit enable from the MAC
    input  wire logic        tx_er_i,            // Transmit error from the MAC
    input  wire logic        rmii_mode_i,        // RMII interface selected
    input  wire logic        eq_err_i,           // Equalizer error indication
    input  wire logic        desc_loss_i,        // Descrambler lost lock
    input  wire logic [3:0]  fld_event_i,        // Other fast link down events
    output logic             pd_fast_o,          // Fast parallel-detect link-up
    output logic             full_duplex_o,      // Resolved duplex is full
    output logic             led_link_o,         // Link LED drive, high is lit
    output logic             mii_isolate_o,      // MII outputs isolated
    output logic             rx_er_idle_o,       // Idle symbol error report
    output logic             tx_en_o,            // Transmit enable to the coder
    output logic             tx_er_o,            // Transmit error to the coder
    output logic             rmii_rclk_sel_o,    // High: RXD timed to RX_CLK
    output logic             eq_err_o,           // Equalizer error passed on
    output logic             link_drop_o         // Fast link drop request
);
    import phylc_pkg::*;

    phylc_state_s st_r;
    phylc_state_s st_nxt;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  sel);
        logic [15:0] res;
        res = old;
        if (sel[0]) begin
            res[7:0] = wd[7:0];
        end
        if (sel[1]) begin
            res[15:8] = wd[15:8];
        end
        return res;
    endfunction

    // Any enabled fast link down event; shared by the drop logic and its checks
    function automatic logic fld_hit(input logic [3:0] ev,
                                     input logic [3:0] en);
        return |(ev & en);
    endfunction

    logic req;
    logic fd_ext;
    logic fd;
    logic is100fd;
    logic odd_end;

    always_comb begin
        st_nxt  = st_r;
        // Ack high blocks a second take while the master still holds stb
        req     = wb_cyc_i & wb_stb_i & ~st_r.ack;
        st_nxt.ack = req;
        if (req) begin
            unique case (wb_adr_i)
                PHYLC_ADR_CTL_TWO: begin
                    st_nxt.dat = {16'h0000, st_r.ctl_two};
                end
                PHYLC_ADR_CTL_THREE: begin
                    st_nxt.dat = {16'h0000, st_r.ctl_three};
                end
                PHYLC_ADR_STATUS: begin
                    // Snapshot of the registered outputs, read only
                    st_nxt.dat = {22'h000000, st_r.ctl};
                end
                default: begin
                    st_nxt.dat = 32'h00000000;
                end
            endcase
            // Only byte lanes 0 and 1 carry register bits
            if (wb_we_i && wb_adr_i == PHYLC_ADR_CTL_TWO) begin
                st_nxt.ctl_two = merge16(st_r.ctl_two, wb_dat_i, wb_sel_i);
            end
            if (wb_we_i && wb_adr_i == PHYLC_ADR_CTL_THREE) begin
                st_nxt.ctl_three = merge16(st_r.ctl_three, wb_dat_i, wb_sel_i);
            end
        end
        // Hardware set wins over a software write of zero
        if (mdix_fast_i | mdix_robust_i) begin
            st_nxt.ctl_two[PHYLC_B_PD_FAST] = 1'b1; // R2
        end
        st_nxt.ctl.pd_fast = st_r.ctl_two[PHYLC_B_PD_FAST]; // R1

        // Recomputed every cycle, so a partner change shows without latching
        fd_ext = st_r.ctl_two[PHYLC_B_EXT_FD] & (local_an_i | local_f100_i) & partner_f100_i;
        fd     = fd_ext | ieee_full_i; // R3 R4
        st_nxt.ctl.full_duplex = fd;

        is100fd = link_up_i & link_100_i & fd;
        if (st_r.ctl_two[PHYLC_B_ENH_LED]) begin
            st_nxt.ctl.led_link = is100fd; // R5 R6
        end else begin
            // Blink dims the LED only in normal mode
            st_nxt.ctl.led_link = link_up_i & ~activity_i; // R7
        end

        st_nxt.ctl.mii_isolate = st_r.ctl_two[PHYLC_B_ISOLATE] & link_up_i
                                 & (~link_100_i | ~fd); // R8
        st_nxt.ctl.rx_er_idle  = st_r.ctl_two[PHYLC_B_IDLE_ERR] & idle_sym_err_i; // R9

        // Parity counts nibbles of the frame; an odd count at the falling
        // edge of enable means a dangling nibble that must be poisoned.
        odd_end = 1'b0;
        if (tx_tick_i) begin
            odd_end = st_r.tx_en_d & ~tx_en_i & st_r.nib_odd
                      & ~st_r.ctl_two[PHYLC_B_ODD_DIS]; // R10
            st_nxt.tx_en_d = tx_en_i;
            st_nxt.nib_odd = tx_en_i ? ~st_r.nib_odd : 1'b0;
            st_nxt.ctl.tx_en = tx_en_i | odd_end; // R11
            st_nxt.ctl.tx_er = (tx_er_i & tx_en_i) | odd_end; // R11
        end

        // Outside RMII the select stays low whatever the bit holds
        st_nxt.ctl.rmii_rclk_sel = rmii_mode_i & st_r.ctl_two[PHYLC_B_RMII_RCLK]; // R12
        // Bypass is set at reset, so equalizer noise stays masked until cleared
        st_nxt.ctl.eq_err = eq_err_i & ~st_r.ctl_three[PHYLC_B_EQ_BYP]; // R13
        st_nxt.ctl.link_drop = (desc_loss_i & st_r.ctl_three[PHYLC_B_DESC_DROP]) // R14
                             | fld_hit(fld_event_i, st_r.ctl_three[PHYLC_FLD_MSB:0]); // R15
    end

    // Reset ignores the enable so a frozen block still comes up clean
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_r           <= '0;
            st_r.ctl_two   <= PHYLC_CTL_TWO_RST;
            st_r.ctl_three <= PHYLC_CTL_THREE_RST;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    // Every output is a field of the registered state
    assign wb_dat_o        = st_r.dat;
    assign wb_ack_o        = st_r.ack;
    assign pd_fast_o       = st_r.ctl.pd_fast;
    assign full_duplex_o   = st_r.ctl.full_duplex;
    assign led_link_o      = st_r.ctl.led_link;
    assign mii_isolate_o   = st_r.ctl.mii_isolate;
    assign rx_er_idle_o    = st_r.ctl.rx_er_idle;
    assign tx_en_o         = st_r.ctl.tx_en;
    assign tx_er_o         = st_r.ctl.tx_er;
    assign rmii_rclk_sel_o = st_r.ctl.rmii_rclk_sel;
    assign eq_err_o        = st_r.ctl.eq_err;
    assign link_drop_o     = st_r.ctl.link_drop;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    AST_PD_AUTOSET: assert property ( // R2
        ce_i && (mdix_fast_i || mdix_robust_i) ##1 ce_i |=> pd_fast_o)
        else $error("fast link-up bit not set by crossover mode");

    AST_PD_FOLLOW: assert property ( // R1
        ce_i |=> pd_fast_o == $past(st_r.ctl_two[PHYLC_B_PD_FAST]))
        else $error("fast link-up output does not track register");

    AST_EXT_FD: assert property ( // R3
        ce_i && st_r.ctl_two[PHYLC_B_EXT_FD] && local_an_i && partner_f100_i |=> full_duplex_o)
        else $error("extended duplex did not force full duplex");

    AST_STD_FD: assert property ( // R4
        ce_i && !st_r.ctl_two[PHYLC_B_EXT_FD] |=> full_duplex_o == $past(ieee_full_i))
        else $error("duplex does not follow standard resolution");

    AST_ENH_LED: assert property ( // R5
        ce_i && st_r.ctl_two[PHYLC_B_ENH_LED] && !link_100_i |=> !led_link_o)
        else $error("enhanced LED lit without 100 full duplex link");

    AST_ENH_NOBLINK: assert property ( // R6
        ce_i && st_r.ctl_two[PHYLC_B_ENH_LED] && is100fd && activity_i |=> led_link_o)
        else $error("enhanced LED blinked on activity");

    AST_NORM_LED: assert property ( // R7
        ce_i && !st_r.ctl_two[PHYLC_B_ENH_LED] && !activity_i |=> led_link_o == $past(link_up_i))
        else $error("normal LED does not follow link");

    AST_ISOLATE: assert property ( // R8
        ce_i && st_r.ctl_two[PHYLC_B_ISOLATE] && link_up_i && !link_100_i |=> mii_isolate_o)
        else $error("MII not isolated on 10 link");

    AST_IDLE_ERR: assert property ( // R9
        ce_i |=> rx_er_idle_o == $past(st_r.ctl_two[PHYLC_B_IDLE_ERR] && idle_sym_err_i))
        else $error("idle error report wrong");

    AST_ODD_STRETCH: assert property ( // R11
        ce_i && tx_tick_i && odd_end |=> tx_en_o && tx_er_o)
        else $error("odd nibble did not stretch enable with error");

    AST_ODD_DIS: assert property ( // R10
        ce_i && tx_tick_i && st_r.ctl_two[PHYLC_B_ODD_DIS] && !tx_en_i |=> !tx_en_o)
        else $error("odd nibble handling while disabled");

    AST_RMII_SEL: assert property ( // R12
        ce_i |=> rmii_rclk_sel_o == $past(rmii_mode_i && st_r.ctl_two[PHYLC_B_RMII_RCLK]))
        else $error("receive clock select wrong");

    AST_EQ_BYP: assert property ( // R13
        ce_i && st_r.ctl_three[PHYLC_B_EQ_BYP] |=> !eq_err_o)
        else $error("equalizer error passed while bypassed");

    AST_DESC_DROP: assert property ( // R14
        ce_i && desc_loss_i && st_r.ctl_three[PHYLC_B_DESC_DROP] |=> link_drop_o)
        else $error("no link drop on descrambler loss");

    AST_FLD_COMB: assert property ( // R15
        ce_i && !desc_loss_i && (fld_event_i & st_r.ctl_three[3:0]) == 4'h0 |=> !link_drop_o)
        else $error("spurious link drop");

    AST_ACK_PULSE: assert property (
        ce_i && wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    // Register bus: ack rises on the same enabled edge that takes the request
    AST_ACK_LATENCY: assert property (
        ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request taken without ack");

    AST_ACK_IDLE: assert property (
        ce_i && !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without a request");

    AST_RD_UPPER: assert property (
        wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read half not zero");

    // Full writes land as written while no crossover mode forces the fast bit
    AST_WR_TWO: assert property (
        ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[1:0] == 2'h3
        && wb_adr_i == PHYLC_ADR_CTL_TWO && !mdix_fast_i && !mdix_robust_i
        |=> st_r.ctl_two == $past(wb_dat_i[15:0]))
        else $error("control two write lost");

    AST_WR_THREE: assert property (
        ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[1:0] == 2'h3
        && wb_adr_i == PHYLC_ADR_CTL_THREE |=> st_r.ctl_three == $past(wb_dat_i[15:0]))
        else $error("control three write lost");

    // A low enable freezes every bit of state, bus included
    AST_CE_FREEZE: assert property (
        !ce_i |=> $stable(st_r))
        else $error("state moved while enable low");

    // Transmit outputs move only on ticks; a stretch lasts one tick
    AST_TX_HOLD: assert property (
        ce_i && !tx_tick_i |=> $stable(tx_en_o) && $stable(tx_er_o))
        else $error("transmit outputs moved between ticks");

    AST_TX_PASS: assert property (
        ce_i && tx_tick_i && tx_en_i |=> tx_en_o && tx_er_o == $past(tx_er_i))
        else $error("transmit enable or error not passed through");

    AST_ODD_DETECT: assert property ( // R10
        ce_i && tx_tick_i && !tx_en_i && st_r.tx_en_d && st_r.nib_odd
        && !st_r.ctl_two[PHYLC_B_ODD_DIS] |=> tx_en_o && tx_er_o)
        else $error("odd nibble end not detected");

    AST_ODD_EVEN: assert property ( // R10
        ce_i && tx_tick_i && !tx_en_i && !st_r.nib_odd |=> !tx_en_o && !tx_er_o)
        else $error("stretch without an odd nibble");

    AST_ODD_ONCE: assert property ( // R11
        ce_i && tx_tick_i && !tx_en_i && !st_r.tx_en_d |=> !tx_en_o && !tx_er_o)
        else $error("stretch lasted more than one tick");

    // Isolation and LED corners
    AST_ISO_100HD: assert property ( // R8
        ce_i && st_r.ctl_two[PHYLC_B_ISOLATE] && link_up_i && link_100_i && !ieee_full_i
        && !st_r.ctl_two[PHYLC_B_EXT_FD] |=> mii_isolate_o)
        else $error("MII not isolated on 100 half duplex link");

    AST_ISO_OFF: assert property ( // R8
        ce_i && !st_r.ctl_two[PHYLC_B_ISOLATE] |=> !mii_isolate_o)
        else $error("MII isolated with isolate bit clear");

    AST_NORM_BLINK: assert property ( // R7
        ce_i && !st_r.ctl_two[PHYLC_B_ENH_LED] && activity_i |=> !led_link_o)
        else $error("normal LED not dimmed by activity");

    // Masking and descrambler drop with the enables cleared; drop on any enabled fast link down event
    AST_EQ_PASS: assert property ( // R13
        ce_i && !st_r.ctl_three[PHYLC_B_EQ_BYP] |=> eq_err_o == $past(eq_err_i))
        else $error("equalizer error not passed while unmasked");

    AST_DESC_KEEP: assert property ( // R14
        ce_i && desc_loss_i && !st_r.ctl_three[PHYLC_B_DESC_DROP]
        && !fld_hit(fld_event_i, st_r.ctl_three[PHYLC_FLD_MSB:0]) |=> !link_drop_o)
        else $error("link dropped with descrambler drop disabled");

    AST_FLD_ANY: assert property ( // R15
        ce_i && fld_hit(fld_event_i, st_r.ctl_three[PHYLC_FLD_MSB:0]) |=> link_drop_o)
        else $error("enabled fast link down event ignored");

    // Scenario covers
    COV_WRITE_TWO: cover property (
        wb_ack_o && wb_we_i && wb_adr_i == PHYLC_ADR_CTL_TWO);
    COV_ODD_END: cover property (tx_tick_i && odd_end);
    COV_ENH_LED_ON: cover property (st_r.ctl_two[PHYLC_B_ENH_LED] && led_link_o);
    COV_DROP: cover property (link_drop_o);
    COV_CE_FREEZE: cover property (!ce_i ##1 ce_i);

endmodule

// ===== testbench/phylc_mac_model.sv
`timescale 1ns/1ns
module phylc_mac_model (
    input  wire logic clk_i,       // System clock
    input  wire logic rclk_sel_i,  // Receive data clock choice from the PHY
    output logic      tx_tick_o,   // One pulse per transmit clock cycle
    output logic      tx_en_o,     // Transmit enable
    output logic      tx_er_o,     // Transmit error, never raised here
    output logic      rx_on_ref_o  // High: receive data sampled on the reference clock
);
    initial begin
        tx_tick_o = 1'b0;
        tx_en_o   = 1'b0;
        tx_er_o   = 1'b0;
    end
    assign rx_on_ref_o = ~rclk_sel_i;
    // Ticks every second cycle, like a slower TX_CLK; one low-enable tick closes the frame
    task automatic send(input logic [1:0] n);
        for (int i = 0; i <= n; i++) begin
            @(posedge clk_i);
            tx_tick_o <= 1'b1;
            tx_en_o   <= (i < n);
            @(posedge clk_i);
            tx_tick_o <= 1'b0;
        end
    endtask
endmodule

// ===== testbench/phylc_top_tb.sv
`timescale 1ns/1ns
module phylc_top_tb;
    import phylc_pkg::*;
    logic        clk_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic        mdix_fast_i = 1'b0, mdix_robust_i = 1'b0, link_up_i = 1'b0;
    logic        link_100_i = 1'b0, ieee_full_i = 1'b0, local_an_i = 1'b0;
    logic        local_f100_i = 1'b0, partner_f100_i = 1'b0, activity_i = 1'b0;
    logic        idle_sym_err_i = 1'b0, rmii_mode_i = 1'b0, eq_err_i = 1'b0;
    logic        desc_loss_i = 1'b0, tx_tick_i, tx_en_i, tx_er_i;
    logic [3:0]  fld_event_i = 4'h0;
    logic        pd_fast_o, full_duplex_o, led_link_o, mii_isolate_o, rx_er_idle_o;
    logic        tx_en_o, tx_er_o, rmii_rclk_sel_o, eq_err_o, link_drop_o;
    int          miscompares = 0, checks = 0;
    // Rows: enh, link, 100, full, activity, expected led, expected isolate
    logic [6:0]  led_tab [6] = '{7'h7e, 7'h71, 7'h69, 7'h23, 7'h18, 7'h3c};
    // Rows: nibble count, disable bit, expected stretch
    logic [3:0]  tx_tab [4] = '{4'hd, 4'he, 4'h8, 4'h5};

    phylc_top u_phylc_top (.clk_i, .sys_rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .mdix_fast_i, .mdix_robust_i,
        .link_up_i, .link_100_i, .ieee_full_i, .local_an_i, .local_f100_i, .partner_f100_i,
        .activity_i, .idle_sym_err_i, .tx_tick_i, .tx_en_i, .tx_er_i, .rmii_mode_i,
        .eq_err_i, .desc_loss_i, .fld_event_i, .pd_fast_o, .full_duplex_o, .led_link_o,
        .mii_isolate_o, .rx_er_idle_o, .tx_en_o, .tx_er_o, .rmii_rclk_sel_o, .eq_err_o,
        .link_drop_o);
    phylc_mac_model u_phylc_mac_model (.clk_i, .rclk_sel_i(rmii_rclk_sel_o),
        .tx_tick_o(tx_tick_i), .tx_en_o(tx_en_i), .tx_er_o(tx_er_i), .rx_on_ref_o());

    always #10 clk_i = ~clk_i;

    task automatic print_verdict;
        if (miscompares == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Returns at the ack edge, so a following non-blocking drive lands on a rising edge
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'h3;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        chk("wb_ack", 32'h1, {31'h0, wb_ack_o});
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask
    // Outputs are registered and some derive from others, so allow three edges
    task automatic st;
        repeat (3) @(posedge clk_i);
        #1;
    endtask

    initial begin
        #100000;
        miscompares++;
        print_verdict();
    end

    initial begin
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rchk("ctl_two", PHYLC_ADR_CTL_TWO, 32'h0000_0100);
        rchk("ctl_three", PHYLC_ADR_CTL_THREE, 32'h0000_1000);
        wb(1'b1, 8'h3c, 32'h0000_ffff);
        rchk("unmapped", 8'h3c, 32'h0);
        eq_err_i    <= 1'b1;
        mdix_fast_i <= 1'b1;
        st();
        chk("eq_err", 32'h0, {31'h0, eq_err_o});
        chk("pd_fast", 32'h1, {31'h0, pd_fast_o});
        rchk("ctl_two", PHYLC_ADR_CTL_TWO, 32'h0000_0140);
        wb(1'b1, PHYLC_ADR_CTL_THREE, 32'h0);
        mdix_fast_i <= 1'b0;
        wb(1'b1, PHYLC_ADR_CTL_TWO, 32'h0000_0100);
        st();
        chk("pd_fast", 32'h0, {31'h0, pd_fast_o});
        chk("eq_err", 32'h1, {31'h0, eq_err_o});
        rchk("status", PHYLC_ADR_STATUS, 32'h0000_0002);
        mdix_robust_i  <= 1'b1;
        local_an_i     <= 1'b1;
        partner_f100_i <= 1'b1;
        wb(1'b1, PHYLC_ADR_CTL_TWO, 32'h0000_0120);
        st();
        chk("pd_fast", 32'h1, {31'h0, pd_fast_o});
        chk("full_duplex", 32'h1, {31'h0, full_duplex_o});
        wb(1'b1, PHYLC_ADR_CTL_TWO, 32'h0000_0100);
        mdix_robust_i <= 1'b0;
        st();
        chk("full_duplex", 32'h0, {31'h0, full_duplex_o});
        for (int i = 0; i < 6; i++) begin
            wb(1'b1, PHYLC_ADR_CTL_TWO, {27'h0, led_tab[i][6], 4'h8} | 32'h0100);
            {link_up_i, link_100_i, ieee_full_i, activity_i} <= led_tab[i][5:2];
            st();
            chk("led_link", {31'h0, led_tab[i][1]}, {31'h0, led_link_o});
            chk("mii_isolate", {31'h0, led_tab[i][0]}, {31'h0, mii_isolate_o});
        end
        wb(1'b1, PHYLC_ADR_CTL_TWO, 32'h0000_0105);
        idle_sym_err_i <= 1'b1;
        rmii_mode_i    <= 1'b1;
        st();
        chk("rx_er_idle", 32'h1, {31'h0, rx_er_idle_o});
        chk("rmii_rclk_sel", 32'h1, {31'h0, rmii_rclk_sel_o});
        wb(1'b1, PHYLC_ADR_CTL_TWO, 32'h0000_0100);
        st();
        chk("rx_er_idle", 32'h0, {31'h0, rx_er_idle_o});
        chk("rmii_rclk_sel", 32'h0, {31'h0, rmii_rclk_sel_o});
        wb(1'b1, PHYLC_ADR_CTL_THREE, 32'h0000_1400);
        desc_loss_i <= 1'b1;
        st();
        chk("link_drop", 32'h1, {31'h0, link_drop_o});
        wb(1'b1, PHYLC_ADR_CTL_THREE, 32'h0000_1004);
        st();
        chk("link_drop", 32'h0, {31'h0, link_drop_o});
        wb(1'b1, PHYLC_ADR_CTL_THREE, 32'h0000_1404);
        fld_event_i <= 4'h4;
        desc_loss_i <= 1'b0;
        st();
        chk("link_drop", 32'h1, {31'h0, link_drop_o});
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, PHYLC_ADR_CTL_TWO, {30'h0, tx_tab[i][1], 1'b0} | 32'h0100);
            u_phylc_mac_model.send(tx_tab[i][3:2]);
            #1;
            chk("tx_en", {31'h0, tx_tab[i][0]}, {31'h0, tx_en_o});
            chk("tx_er", {31'h0, tx_tab[i][0]}, {31'h0, tx_er_o});
        end
        // Enable low must hold the drop output although its event has gone
        @(posedge clk_i);
        ce_i        <= 1'b0;
        fld_event_i <= 4'h0;
        st();
        chk("ce_hold", 32'h1, {31'h0, link_drop_o});
        @(posedge clk_i);
        ce_i <= 1'b1;
        st();
        chk("ce_run", 32'h0, {31'h0, link_drop_o});
        print_verdict();
    end
endmodule
